// ### rtl/sse_alu.sv
/*
 * Combinational result unit: subtract, XOR and nibble swap with flag
 * results and destination selection. Assumes the caller applies the
 * result only in the cycle the operation is issued.
 */
`timescale 1ns/1ns
`default_nettype none

module sse_alu
(
    // Operation
    input wire sse_pkg::sse_op_t op,
    input wire logic dest,
    // Operands
    input wire logic [sse_pkg::DATA_W-1:0] acc,
    input wire logic [sse_pkg::DATA_W-1:0] fval,
    input wire logic [sse_pkg::DATA_W-1:0] lit,
    // Result
    output var sse_pkg::sse_alu_res_t res
);

    logic [sse_pkg::DATA_W:0] diff;
    logic [sse_pkg::NIB_W:0] ndiff;
    logic [sse_pkg::DATA_W-1:0] minuend;

    always_comb
    begin
        minuend = (op == sse_pkg::op_literal_minus_acc) ? lit : fval;
        diff = {1'b0, minuend} - {1'b0, acc};
        ndiff = {1'b0, minuend[sse_pkg::NIB_W-1:0]} - {1'b0, acc[sse_pkg::NIB_W-1:0]};
        res = '0;
        // Borrow out of the top bit means acc exceeded the minuend
        res.borrow_inverse = ~diff[sse_pkg::DATA_W];
        res.half_borrow = ~ndiff[sse_pkg::NIB_W];
        unique case (op)
            sse_pkg::op_none:
            begin
                res.value = sse_pkg::RST_BYTE;
            end
            sse_pkg::op_halt:
            begin
                res.halt = 1'b1;
            end
            sse_pkg::op_literal_minus_acc:
            begin
                res.value = diff[sse_pkg::DATA_W-1:0];
                res.upd_borrow = 1'b1;
                res.upd_nil = 1'b1;
                res.to_acc = 1'b1;
            end
            sse_pkg::op_file_minus_acc:
            begin
                res.value = diff[sse_pkg::DATA_W-1:0];
                res.upd_borrow = 1'b1;
                res.upd_nil = 1'b1;
                res.to_acc = ~dest;
                res.to_file = dest;
            end
            sse_pkg::op_xor_acc_file:
            begin
                res.value = acc ^ fval;
                res.upd_nil = 1'b1;
                res.to_acc = ~dest;
                res.to_file = dest;
            end
            sse_pkg::op_xor_acc_literal:
            begin
                res.value = acc ^ lit;
                res.upd_nil = 1'b1;
                res.to_acc = 1'b1;
            end
            sse_pkg::op_nibble_exchange:
            begin
                res.value = {fval[sse_pkg::NIB_W-1:0],
                             fval[sse_pkg::DATA_W-1:sse_pkg::NIB_W]};
                res.to_acc = ~dest;
                res.to_file = dest;
            end
            // Software may write an unused code; it does nothing
            default:
            begin
                res.value = sse_pkg::RST_BYTE;
            end
        endcase
        res.nil = (res.value == sse_pkg::RST_BYTE);
    end

endmodule : sse_alu

`default_nettype wire

// ### rtl/sse_exec.sv
/*
 * Execution block for halt, subtract, XOR and nibble swap operations,
 * with accumulator, status flags, watchdog counter and file registers
 * behind a plain strobe register port.
 * Assumes one strobe per cycle and read data taken the cycle after.
 */
//
// Contract
// - Halt clears powerdown_flag and sets timeout_flag.
// - Halt zeroes the watchdog counter and its prescaler.
// - After halt the core sleeps with the oscillator stopped.
// - Literal minus acc; borrow flags from full byte and low nibble.
// - Literal minus acc always writes the accumulator, never a file register.
// - File minus acc; borrow flags from full byte and low nibble.
// - File minus acc: destination 0 to accumulator, 1 to file register.
// - XOR acc with file; destination selects target; only zero flag changes.
// - Nibble swap of file register; no flag changes.
// - Nibble swap: destination 0 to accumulator, 1 to file register.
// - XOR acc with literal into accumulator; only zero flag changes.
`timescale 1ns/1ns
`default_nettype none

module sse_exec
#(
    parameter int WDT_W = 8,
    parameter int PRESC_W = 8
)
(
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // Register port
    input wire sse_pkg::sse_bus_req_t bus,
    output var logic [sse_pkg::DATA_W-1:0] rdata,
    // Power state
    output var logic osc_enable,
    output var logic core_asleep
);

    // ==========================================================
    // State
    // ==========================================================
    typedef struct packed {
        sse_pkg::sse_pwr_t pwr;
        logic [sse_pkg::DATA_W-1:0] acc;
        logic carry;
        logic half_borrow;
        logic result_nil;
        logic timeout_flag;
        logic powerdown_flag;
        logic [sse_pkg::DATA_W-1:0] fsel;
        logic [sse_pkg::DATA_W-1:0] lit;
        logic [WDT_W-1:0] watchdog_counter;
        logic [PRESC_W-1:0] presc;
        logic [sse_pkg::DATA_W-1:0] rdata;
        logic osc_enable;
    } sse_exec_state_t;

    sse_exec_state_t st;
    sse_exec_state_t next_st;

    logic is_exec;
    sse_pkg::sse_op_t exec_op;
    sse_pkg::sse_alu_res_t alu_res;
    logic fsel_dest;
    logic [sse_pkg::FILE_AW-1:0] fsel_addr;
    logic [sse_pkg::FILE_AW-1:0] bus_faddr;
    logic bus_file;
    logic file_we;
    logic [sse_pkg::FILE_AW-1:0] file_waddr;
    logic [sse_pkg::DATA_W-1:0] file_wdata;
    logic [sse_pkg::FILE_AW-1:0] file_raddr;
    logic [sse_pkg::DATA_W-1:0] file_rd;
    logic [sse_pkg::DATA_W-1:0] swapped;
    logic [sse_pkg::DATA_W-1:0] status_rd;

    // ==========================================================
    // Decode
    // ==========================================================
    assign fsel_dest = st.fsel[sse_pkg::FSEL_DEST_BIT];
    assign fsel_addr = st.fsel[sse_pkg::FILE_AW-1:0];
    assign bus_faddr = bus.addr[sse_pkg::FILE_AW-1:0];
    assign bus_file = bus.addr[sse_pkg::FILE_WIN_BIT];
    // Stopped oscillator: no operation issues until reset
    assign is_exec = bus.wr && !bus_file && (bus.addr == sse_pkg::OFS_EXEC)
                     && (st.pwr == sse_pkg::st_run);
    assign exec_op = is_exec ? sse_pkg::sse_op_t'(bus.wdata[sse_pkg::OP_LSB +: sse_pkg::OP_W])
                             : sse_pkg::op_none;
    assign swapped = {file_rd[sse_pkg::NIB_W-1:0], file_rd[sse_pkg::DATA_W-1:sse_pkg::NIB_W]};

    sse_alu u_alu
    (
        .op(exec_op),
        .dest(fsel_dest),
        .acc(st.acc),
        .fval(file_rd),
        .lit(st.lit),
        .res(alu_res)
    );

    // ==========================================================
    // File registers
    // ==========================================================
    // Only one strobe per cycle, so operation and bus never collide
    assign file_we = alu_res.to_file
                     || (bus.wr && bus_file && (st.pwr == sse_pkg::st_run));
    assign file_waddr = alu_res.to_file ? fsel_addr : bus_faddr;
    assign file_wdata = alu_res.to_file ? alu_res.value : bus.wdata;
    assign file_raddr = is_exec ? fsel_addr : bus_faddr;

    sse_filemem u_filemem
    (
        .clk_sys(clk_sys),
        .rst(rst),
        .wr_en(file_we),
        .wr_addr(file_waddr),
        .wr_data(file_wdata),
        .rd_addr(file_raddr),
        .rd_data(file_rd)
    );

    // ==========================================================
    // Next state
    // ==========================================================
    always_comb
    begin
        next_st = st;
        status_rd = sse_pkg::RST_BYTE;
        status_rd[sse_pkg::ST_CARRY] = st.carry;
        status_rd[sse_pkg::ST_HALF] = st.half_borrow;
        status_rd[sse_pkg::ST_NIL] = st.result_nil;
        status_rd[sse_pkg::ST_PD] = st.powerdown_flag;
        status_rd[sse_pkg::ST_TO] = st.timeout_flag;
        status_rd[sse_pkg::ST_SLEEP] = (st.pwr == sse_pkg::st_asleep);

        // Watchdog freezes while the oscillator is stopped
        if (st.pwr == sse_pkg::st_run)
        begin
            next_st.presc = st.presc + 1'b1;
            if (st.presc == '1)
            begin
                next_st.watchdog_counter = st.watchdog_counter + 1'b1;
            end
        end

        if (bus.wr && !bus_file && (st.pwr == sse_pkg::st_run))
        begin
            if (bus.addr == sse_pkg::OFS_ACC)
            begin
                next_st.acc = bus.wdata;
            end
            if (bus.addr == sse_pkg::OFS_STATUS)
            begin
                next_st.carry = bus.wdata[sse_pkg::ST_CARRY];
                next_st.half_borrow = bus.wdata[sse_pkg::ST_HALF];
                next_st.result_nil = bus.wdata[sse_pkg::ST_NIL];
            end
            if (bus.addr == sse_pkg::OFS_FSEL)
            begin
                next_st.fsel = bus.wdata;
            end
            if (bus.addr == sse_pkg::OFS_LIT)
            begin
                next_st.lit = bus.wdata;
            end
        end

        if (alu_res.to_acc)
        begin
            next_st.acc = alu_res.value;
        end
        if (alu_res.upd_borrow)
        begin
            next_st.carry = alu_res.borrow_inverse;
            next_st.half_borrow = alu_res.half_borrow;
        end
        if (alu_res.upd_nil)
        begin
            next_st.result_nil = alu_res.nil;
        end
        if (alu_res.halt)
        begin
            next_st.powerdown_flag = 1'b0;
            next_st.timeout_flag = 1'b1;
            next_st.watchdog_counter = '0;
            next_st.presc = '0;
            next_st.pwr = sse_pkg::st_asleep;
            next_st.osc_enable = 1'b0;
        end

        // Read data stands for exactly one cycle, zero otherwise
        next_st.rdata = sse_pkg::RST_BYTE;
        if (bus.rd)
        begin
            if (bus_file)
            begin
                next_st.rdata = file_rd;
            end
            else
            begin
                unique case (bus.addr)
                    sse_pkg::OFS_ACC: next_st.rdata = st.acc;
                    sse_pkg::OFS_STATUS: next_st.rdata = status_rd;
                    sse_pkg::OFS_FSEL: next_st.rdata = st.fsel;
                    sse_pkg::OFS_LIT: next_st.rdata = st.lit;
                    sse_pkg::OFS_WDT: next_st.rdata = sse_pkg::DATA_W'(st.watchdog_counter);
                    sse_pkg::OFS_PRESC: next_st.rdata = sse_pkg::DATA_W'(st.presc);
                    default: next_st.rdata = sse_pkg::RST_BYTE;
                endcase
            end
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            st <= '0;
            st.pwr <= sse_pkg::st_run;
            st.timeout_flag <= sse_pkg::RST_TO;
            st.powerdown_flag <= sse_pkg::RST_PD;
            st.osc_enable <= 1'b1;
        end
        else
        begin
            st <= next_st;
        end
    end

    assign rdata = st.rdata;
    assign osc_enable = st.osc_enable;
    assign core_asleep = (st.pwr == sse_pkg::st_asleep);

    // ==========================================================
    // Assertions
    // ==========================================================
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (rst);

    halt_flags_a: assert property (exec_op == sse_pkg::op_halt
        |=> !st.powerdown_flag && st.timeout_flag)
        else $error("halt did not update power flags");

    halt_wdt_a: assert property (exec_op == sse_pkg::op_halt
        |=> st.watchdog_counter == '0 && st.presc == '0)
        else $error("halt did not clear watchdog");

    halt_sleep_a: assert property (exec_op == sse_pkg::op_halt
        |=> (core_asleep && !osc_enable)[*3])
        else $error("halt did not enter sleep");

    subl_value_a: assert property (exec_op == sse_pkg::op_literal_minus_acc
        |=> st.acc == ($past(st.lit) - $past(st.acc))
            && st.carry == ($past(st.acc) <= $past(st.lit)))
        else $error("literal subtract result or borrow wrong");

    subl_dest_a: assert property (exec_op == sse_pkg::op_literal_minus_acc
        |-> !file_we)
        else $error("literal subtract wrote a file register");

    subf_flag_a: assert property (exec_op == sse_pkg::op_file_minus_acc
        |=> st.carry == ($past(st.acc) <= $past(file_rd))
            && st.half_borrow == ($past(st.acc[sse_pkg::NIB_W-1:0])
                <= $past(file_rd[sse_pkg::NIB_W-1:0])))
        else $error("file subtract borrow wrong");

    subf_dest_a: assert property (exec_op == sse_pkg::op_file_minus_acc && fsel_dest
        |-> file_we && file_waddr == fsel_addr
            && file_wdata == (file_rd - st.acc)
        ##1 st.acc == $past(st.acc))
        else $error("file subtract destination wrong");

    xorf_flag_a: assert property (exec_op == sse_pkg::op_xor_acc_file
        |=> st.result_nil == (($past(st.acc) ^ $past(file_rd)) == '0)
            && st.carry == $past(st.carry)
            && st.half_borrow == $past(st.half_borrow))
        else $error("file xor flags wrong");

    swap_flags_a: assert property (exec_op == sse_pkg::op_nibble_exchange
        |=> $stable(st.carry) && $stable(st.half_borrow) && $stable(st.result_nil))
        else $error("nibble swap changed a flag");

    swap_dest_a: assert property (exec_op == sse_pkg::op_nibble_exchange && !fsel_dest
        |=> st.acc == $past(swapped))
        else $error("nibble swap did not reach accumulator");

    xorl_value_a: assert property (exec_op == sse_pkg::op_xor_acc_literal
        |=> st.acc == ($past(st.acc) ^ $past(st.lit)) && $stable(st.carry))
        else $error("literal xor result wrong");

    nil_flag_a: assert property (alu_res.upd_nil
        |=> st.result_nil == ($past(alu_res.value) == '0))
        else $error("zero flag does not match result");

endmodule : sse_exec

`default_nettype wire

// ### rtl/sse_filemem.sv
/*
 * File register storage in flip-flops, one write port and one
 * combinational read port. Assumes writes come from one master per cycle.
 */
`timescale 1ns/1ns
`default_nettype none

module sse_filemem
#(
    parameter int AW = sse_pkg::FILE_AW,
    parameter int DW = sse_pkg::DATA_W
)
(
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // Write port
    input wire logic wr_en,
    input wire logic [AW-1:0] wr_addr,
    input wire logic [DW-1:0] wr_data,
    // Read port
    input wire logic [AW-1:0] rd_addr,
    output logic [DW-1:0] rd_data
);

    typedef struct packed {
        logic [(1<<AW)-1:0][DW-1:0] mem;
    } sse_filemem_state_t;

    sse_filemem_state_t st;
    sse_filemem_state_t next_st;

    always_comb
    begin
        next_st = st;
        if (wr_en)
        begin
            next_st.mem[wr_addr] = wr_data;
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            st <= '0;
        end
        else
        begin
            st <= next_st;
        end
    end

    assign rd_data = st.mem[rd_addr];

endmodule : sse_filemem

`default_nettype wire

// ### rtl/sse_pkg.sv
/*
 * Shared constants and types of the execution block: register offsets,
 * status bit positions, operation codes, power states and bus carriers.
 * Assumes a single clock domain and a plain strobe register port.
 */
`default_nettype none

package sse_pkg;

    // ==========================================================
    // Widths
    // ==========================================================
    localparam int DATA_W = 8;
    localparam int ADDR_W = 8;
    localparam int FILE_AW = 7;
    localparam int OP_W = 3;

    // ==========================================================
    // Register offsets
    // ==========================================================
    localparam logic [ADDR_W-1:0] OFS_ACC = 8'h00;
    localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h01;
    localparam logic [ADDR_W-1:0] OFS_FSEL = 8'h02;
    localparam logic [ADDR_W-1:0] OFS_LIT = 8'h03;
    localparam logic [ADDR_W-1:0] OFS_EXEC = 8'h04;
    localparam logic [ADDR_W-1:0] OFS_WDT = 8'h05;
    localparam logic [ADDR_W-1:0] OFS_PRESC = 8'h06;
    // Address bit that selects the file register window
    localparam int FILE_WIN_BIT = 7;

    // ==========================================================
    // Field positions
    // ==========================================================
    localparam int ST_CARRY = 0;
    localparam int ST_HALF = 1;
    localparam int ST_NIL = 2;
    localparam int ST_PD = 3;
    localparam int ST_TO = 4;
    localparam int ST_SLEEP = 5;
    localparam int FSEL_DEST_BIT = 7;
    localparam int OP_LSB = 0;
    localparam int NIB_W = 4;

    // ==========================================================
    // Reset values
    // ==========================================================
    localparam logic [DATA_W-1:0] RST_BYTE = 8'h00;
    localparam logic RST_TO = 1'b1;
    localparam logic RST_PD = 1'b1;

    // ==========================================================
    // Types
    // ==========================================================
    typedef enum logic [OP_W-1:0] {
        op_none = 3'h0,
        op_halt = 3'h1,
        op_literal_minus_acc = 3'h2,
        op_file_minus_acc = 3'h3,
        op_xor_acc_file = 3'h4,
        op_xor_acc_literal = 3'h5,
        op_nibble_exchange = 3'h6
    } sse_op_t;

    typedef enum logic [1:0] {
        st_run = 2'b01,
        st_asleep = 2'b10
    } sse_pwr_t;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic wr;
        logic rd;
    } sse_bus_req_t;

    typedef struct packed {
        logic [DATA_W-1:0] value;
        logic borrow_inverse;
        logic half_borrow;
        logic nil;
        logic upd_borrow;
        logic upd_nil;
        logic to_acc;
        logic to_file;
        logic halt;
    } sse_alu_res_t;

endpackage : sse_pkg

`default_nettype wire

// ### verif/tb_sse_exec.sv
/*
 * Self-checking testbench of the execution block: drives the register
 * port with read and write tasks and checks results, flags and sleep.
 * Assumes the register map, opcodes and timing of the block's package.
 */
`timescale 1ns/1ns
`default_nettype none

`define CHK(what, exp, got) \
    begin \
        n_tests++; \
        if ((got) !== (exp)) \
        begin \
            num_errors++; \
            $display("unexpected %s: expected %h, seen %h", what, exp, got); \
        end \
    end

module tb_sse_exec;

    // ==========================================================
    // Signals
    // ==========================================================
    logic clk_sys = 1'b0;
    logic rst = 1'b1;
    sse_pkg::sse_bus_req_t bus = '0;
    logic [7:0] rdata;
    logic osc_enable;
    logic core_asleep;
    int num_errors = 0;
    int n_tests = 0;
    int cycles = 0;
    logic [7:0] rd_val;

    sse_exec i_sse_exec (
        .clk_sys(clk_sys),
        .rst(rst),
        .bus(bus),
        .rdata(rdata),
        .osc_enable(osc_enable),
        .core_asleep(core_asleep)
    );

    initial
    begin
        forever #10 clk_sys = ~clk_sys;
    end

    // ==========================================================
    // Timeout
    // ==========================================================
    // Whole run needs well under a thousand cycles
    always @(posedge clk_sys)
    begin
        cycles++;
        if (cycles == 5000)
        begin
            num_errors++;
            wrap_up();
        end
    end

    // ==========================================================
    // Bus tasks
    // ==========================================================
    task automatic bus_wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge clk_sys);
        bus.wr <= 1'b0;
    endtask : bus_wr

    task automatic bus_rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk_sys);
        bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge clk_sys);
        bus.rd <= 1'b0;
        #1;
        d = rdata;
    endtask : bus_rd

    // ==========================================================
    // One operation with operands preset and results checked
    // ==========================================================
    task automatic run_op(input sse_pkg::sse_op_t op, input logic dest,
                          input logic [6:0] fa, input logic [7:0] a,
                          input logic [7:0] f, input logic [7:0] k,
                          input logic [2:0] st);
        logic [7:0] r;
        logic [2:0] fl;
        logic to_file;
        logic [7:0] v;
        fl = st;
        to_file = dest;
        case (op)
            sse_pkg::op_literal_minus_acc:
            begin
                r = k - a;
                fl = {r == 8'h00, a[3:0] <= k[3:0], a <= k};
                to_file = 1'b0;
            end
            sse_pkg::op_file_minus_acc:
            begin
                r = f - a;
                fl = {r == 8'h00, a[3:0] <= f[3:0], a <= f};
            end
            sse_pkg::op_xor_acc_file:
            begin
                r = a ^ f;
                fl[2] = (r == 8'h00);
            end
            sse_pkg::op_xor_acc_literal:
            begin
                r = a ^ k;
                fl[2] = (r == 8'h00);
                to_file = 1'b0;
            end
            default:
            begin
                r = {f[3:0], f[7:4]};
            end
        endcase
        bus_wr(sse_pkg::OFS_ACC, a);
        bus_wr({1'b1, fa}, f);
        bus_wr(sse_pkg::OFS_FSEL, {dest, fa});
        bus_wr(sse_pkg::OFS_LIT, k);
        bus_wr(sse_pkg::OFS_STATUS, {5'h00, st});
        bus_wr(sse_pkg::OFS_EXEC, {5'h00, op});
        bus_rd(sse_pkg::OFS_ACC, v);
        `CHK("accumulator", (to_file ? a : r), v);
        bus_rd({1'b1, fa}, v);
        `CHK("file register", (to_file ? r : f), v);
        bus_rd(sse_pkg::OFS_STATUS, v);
        `CHK("status", {5'h03, fl}, v);
    endtask : run_op

    task automatic wrap_up();
        $display("checks made %0d, mismatches %0d", n_tests, num_errors);
        if (num_errors == 0 && n_tests > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : wrap_up

    // ==========================================================
    // Main sequence
    // ==========================================================
    initial
    begin
        repeat (12) @(posedge clk_sys);
        rst <= 1'b0;

        bus_rd(sse_pkg::OFS_STATUS, rd_val);
        `CHK("status after reset", 8'h18, rd_val);
        `CHK("oscillator after reset", 1'b1, osc_enable);
        bus_rd(8'h07, rd_val);
        `CHK("unmapped read", 8'h00, rd_val);
        $display("test reset and map done");

        // Boundaries of full byte and low nibble borrow
        run_op(sse_pkg::op_literal_minus_acc, 1'b0, 7'h00, 8'h05, 8'h11, 8'h03, 3'h0);
        run_op(sse_pkg::op_literal_minus_acc, 1'b1, 7'h05, 8'h33, 8'h44, 8'h33, 3'h0);
        run_op(sse_pkg::op_literal_minus_acc, 1'b0, 7'h01, 8'h10, 8'h00, 8'h0f, 3'h7);
        run_op(sse_pkg::op_literal_minus_acc, 1'b1, 7'h7f, 8'h01, 8'h99, 8'h20, 3'h7);
        run_op(sse_pkg::op_literal_minus_acc, 1'b0, 7'h02, 8'h00, 8'h00, 8'hff, 3'h0);
        $display("test literal minus acc done");

        run_op(sse_pkg::op_file_minus_acc, 1'b0, 7'h10, 8'h05, 8'h03, 8'h00, 3'h0);
        run_op(sse_pkg::op_file_minus_acc, 1'b1, 7'h7f, 8'h42, 8'h42, 8'h00, 3'h0);
        run_op(sse_pkg::op_file_minus_acc, 1'b1, 7'h00, 8'h01, 8'h20, 8'h00, 3'h7);
        run_op(sse_pkg::op_file_minus_acc, 1'b0, 7'h33, 8'hf8, 8'h0f, 8'h00, 3'h7);
        $display("test file minus acc done");

        run_op(sse_pkg::op_xor_acc_file, 1'b0, 7'h20, 8'h5a, 8'h0f, 8'h00, 3'h3);
        run_op(sse_pkg::op_xor_acc_file, 1'b1, 7'h7f, 8'ha5, 8'ha5, 8'h00, 3'h0);
        run_op(sse_pkg::op_xor_acc_file, 1'b1, 7'h21, 8'h80, 8'h01, 8'h00, 3'h7);
        run_op(sse_pkg::op_xor_acc_literal, 1'b1, 7'h22, 8'h3c, 8'h77, 8'h3c, 3'h3);
        run_op(sse_pkg::op_xor_acc_literal, 1'b0, 7'h23, 8'h3c, 8'h77, 8'hc3, 3'h4);
        $display("test xor done");

        run_op(sse_pkg::op_nibble_exchange, 1'b0, 7'h40, 8'h11, 8'h1e, 8'h00, 3'h7);
        run_op(sse_pkg::op_nibble_exchange, 1'b1, 7'h7f, 8'h00, 8'hc3, 8'h00, 3'h0);
        run_op(sse_pkg::op_nibble_exchange, 1'b1, 7'h41, 8'h00, 8'h00, 8'h00, 3'h5);
        $display("test nibble swap done");

        // Halt, then check that sleep blocks writes until reset
        bus_wr(sse_pkg::OFS_ACC, 8'h6e);
        // Unused code 07 and op_none (00) must leave acc, file and flags alone
        bus_wr(sse_pkg::OFS_EXEC, 8'h07);
        bus_wr(sse_pkg::OFS_EXEC, 8'h00);
        bus_wr(sse_pkg::OFS_EXEC, {5'h00, sse_pkg::op_halt});
        #1;
        `CHK("oscillator after halt", 1'b0, osc_enable);
        `CHK("asleep after halt", 1'b1, core_asleep);
        bus_rd(sse_pkg::OFS_STATUS, rd_val);
        // Carry and zero flags from the last swap test are kept
        `CHK("status after halt", 8'h35, rd_val);
        bus_rd(sse_pkg::OFS_WDT, rd_val);
        `CHK("watchdog after halt", 8'h00, rd_val);
        bus_rd(sse_pkg::OFS_PRESC, rd_val);
        `CHK("prescaler after halt", 8'h00, rd_val);
        bus_wr(sse_pkg::OFS_ACC, 8'h01);
        bus_wr(sse_pkg::OFS_EXEC, {5'h00, sse_pkg::op_literal_minus_acc});
        bus_rd(sse_pkg::OFS_ACC, rd_val);
        `CHK("accumulator while asleep", 8'h6e, rd_val);
        @(posedge clk_sys);
        #1;
        `CHK("read data after its cycle", 8'h00, rdata);
        `CHK("still asleep", 1'b1, core_asleep);
        $display("test halt done");

        @(posedge clk_sys);
        rst <= 1'b1;
        @(posedge clk_sys);
        rst <= 1'b0;
        #1;
        `CHK("oscillator after second reset", 1'b1, osc_enable);
        bus_rd(sse_pkg::OFS_STATUS, rd_val);
        `CHK("status after second reset", 8'h18, rd_val);
        $display("test second reset done");

        wrap_up();
    end

endmodule : tb_sse_exec

`default_nettype wire
